//--- wrp_core.sv
// working register pointers, page select and register file page map
`timescale 1ns/1ps
`default_nettype none
module wrp_core #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter bit PAGE2_DISPLAY = 1'b1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register access from the core
  input wire logic [7:0] reg_addr,
  input wire wrp_pkg::wrp_mode_t reg_mode,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // working register lookup: 4-bit r-number to register file address
  input wire logic [3:0] work_sel,
  output logic [7:0] work_addr,
  // pointers and page map
  output logic [7:0] slice_base_a,
  output logic [7:0] slice_base_b,
  output logic [3:0] dst_page,
  output logic [3:0] src_page,
  output logic dst_page_valid,
  output logic src_page_valid,
  output logic dst_page_general,
  output logic src_page_general
);
  import wrp_pkg::*;

  logic [7:0] page_ptr;
  logic [7:0] next_rdata;
  logic [7:0] rdata_q;
  logic hit_q;

  // only register-form access reaches these registers; other modes fall through
  wire mode_ok = (reg_mode == WRP_MODE_REG);
  wire sel_a = mode_ok && (reg_addr == WRP_PTR_A_ADDR);
  wire sel_b = mode_ok && (reg_addr == WRP_PTR_B_ADDR);
  wire sel_pp = mode_ok && (reg_addr == WRP_PP_ADDR);
  wire any_sel = sel_a || sel_b || sel_pp;

  wrp_ptr_reg #(.RESET_VAL(WRP_PTR_A_RESET)) u_ptr_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(reg_wr && sel_a),
    .wr_data(reg_wdata),
    .value(slice_base_a)
  );

  wrp_ptr_reg #(.RESET_VAL(WRP_PTR_B_RESET)) u_ptr_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(reg_wr && sel_b),
    .wr_data(reg_wdata),
    .value(slice_base_b)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      page_ptr <= WRP_PP_RESET;
    end else if (reg_wr && sel_pp) begin
      page_ptr <= reg_wdata;
    end
  end

  // r0-r7 come from slice a, r8-r15 from slice b
  assign work_addr = work_sel[3] ? (slice_base_b | {5'h00, work_sel[2:0]})
                                 : (slice_base_a | {5'h00, work_sel[2:0]});

  assign dst_page = page_ptr[7:4];
  assign src_page = page_ptr[3:0];

  // page 1 exists only on the larger part; unknown pages are flagged, not remapped
  function automatic logic page_exists(input logic [3:0] pg);
    page_exists = (pg == WRP_PAGE0) || (pg == WRP_PAGE2) ||
                  (LARGE_VARIANT && (pg == WRP_PAGE1));
  endfunction : page_exists

  // page 2 is general purpose only when the display does not claim it
  function automatic logic page_general(input logic [3:0] pg);
    page_general = page_exists(pg) && ((pg != WRP_PAGE2) || !PAGE2_DISPLAY);
  endfunction : page_general

  assign dst_page_valid = page_exists(dst_page);
  assign src_page_valid = page_exists(src_page);
  assign dst_page_general = page_general(dst_page);
  assign src_page_general = page_general(src_page);

  assign next_rdata = sel_a ? slice_base_a :
                      sel_b ? slice_base_b :
                      sel_pp ? page_ptr : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
    end else begin
      rdata_q <= reg_rd ? next_rdata : 8'h00;
      hit_q <= (reg_rd || reg_wr) && any_sel;
    end
  end
  assign reg_rdata = rdata_q;
  assign reg_hit = hit_q;

  // checks
  wrp_reset_a_a: assert property (@(posedge clk_sys)
    !rst_n |=> (slice_base_a == {WRP_PTR_A_RESET, 3'h0}) && (slice_base_b == {WRP_PTR_B_RESET, 3'h0}))
    else $error("pointer reset values wrong");

  low_bits_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (slice_base_a[2:0] == 3'h0) && (slice_base_b[2:0] == 3'h0))
    else $error("pointer low bits not zero");

  ptr_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && sel_b |=> slice_base_b == {$past(reg_wdata[7:3]), 3'h0})
    else $error("pointer b write lost");

  ptr_a_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && sel_a |=> slice_base_a == {$past(reg_wdata[7:3]), 3'h0})
    else $error("pointer a write lost");

  bad_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && !mode_ok |=> $stable(slice_base_a) && $stable(slice_base_b))
    else $error("pointer changed by non-register access");

  // a pointer may move only through its own decoded write
  ptr_a_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(reg_wr && sel_a) |=> $stable(slice_base_a))
    else $error("pointer a changed without write");

  ptr_b_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(reg_wr && sel_b) |=> $stable(slice_base_b))
    else $error("pointer b changed without write");

  hit_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !mode_ok |=> !reg_hit && (reg_rdata == 8'h00))
    else $error("non-register access answered");

  write_hit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && any_sel |=> reg_hit)
    else $error("write to block not acknowledged");

  miss_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !any_sel |=> !reg_hit && (reg_rdata == 8'h00))
    else $error("unmapped access answered");

  // read data stands only in the cycle after a read
  no_read_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");

  read_back_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && !reg_wr && sel_a |=> reg_rdata == $past(slice_base_a) && reg_hit)
    else $error("pointer a readback wrong");

  read_b_back_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && !reg_wr && sel_b |=> reg_rdata == $past(slice_base_b) && reg_hit)
    else $error("pointer b readback wrong");

  rdata_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && (sel_a || sel_b) |=> reg_rdata[2:0] == 3'h0)
    else $error("pointer readback low bits set");

  pp_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && sel_pp |=> {dst_page, src_page} == $past(reg_wdata))
    else $error("page pointer write lost");

  pp_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(reg_wr && sel_pp) |=> $stable(dst_page) && $stable(src_page))
    else $error("page pointer changed without write");

  read_pp_back_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && !reg_wr && sel_pp |=> reg_rdata == $past({dst_page, src_page}))
    else $error("page pointer readback wrong");

  page1_gone_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !LARGE_VARIANT && dst_page == WRP_PAGE1 |-> !dst_page_valid)
    else $error("page 1 valid on small part");

  page1_small_src_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !LARGE_VARIANT && src_page == WRP_PAGE1 |-> !src_page_valid && !src_page_general)
    else $error("source page 1 valid on small part");

  page1_large_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    LARGE_VARIANT && src_page == WRP_PAGE1 |-> src_page_valid && src_page_general)
    else $error("page 1 missing on large part");

  page0_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dst_page == WRP_PAGE0 |-> dst_page_valid && dst_page_general)
    else $error("page 0 not general");

  // pages above 2 exist on no variant
  page_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dst_page > WRP_PAGE2 |-> !dst_page_valid && !dst_page_general)
    else $error("nonexistent page flagged valid");

  page2_use_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dst_page == WRP_PAGE2 |-> dst_page_valid && (dst_page_general == !PAGE2_DISPLAY))
    else $error("page 2 use wrong");

  src_page2_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    src_page == WRP_PAGE2 |-> src_page_valid && (src_page_general == !PAGE2_DISPLAY))
    else $error("source page 2 use wrong");

  work_map_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    work_sel[3] |-> work_addr[7:3] == slice_base_b[7:3])
    else $error("upper working registers not in slice b");

  work_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !work_sel[3] |-> work_addr[7:3] == slice_base_a[7:3])
    else $error("lower working registers not in slice a");

  work_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    work_addr[2:0] == work_sel[2:0])
    else $error("working register offset wrong");

  write_a_c: cover property (@(posedge clk_sys) disable iff (!rst_n) reg_wr && sel_a);
  write_pp_c: cover property (@(posedge clk_sys) disable iff (!rst_n) reg_wr && sel_pp);
  read_b_c: cover property (@(posedge clk_sys) disable iff (!rst_n) reg_rd && sel_b);
  bad_mode_c: cover property (@(posedge clk_sys) disable iff (!rst_n) reg_wr && !mode_ok);
  page2_c: cover property (@(posedge clk_sys) disable iff (!rst_n) src_page == 4'h2);
endmodule : wrp_core
`default_nettype wire

//--- wrp_pkg.sv
// package: constants and types for the working register pointer block
// Summary of operation
// - larger variant has register file pages 0, 1, 2; pages 0-1 general purpose
// - smaller variants have only pages 0 and 2; page 1 absent
// - page 2 holds display data or general-purpose registers on all variants
// - pointers reached only by register addressing, no other addressing form
package wrp_pkg;
  localparam logic [7:0] WRP_PTR_A_ADDR = 8'hd6;
  localparam logic [7:0] WRP_PTR_B_ADDR = 8'hd7;
  localparam logic [7:0] WRP_PP_ADDR = 8'hdf;
  localparam logic [4:0] WRP_PTR_A_RESET = 5'h18;
  localparam logic [4:0] WRP_PTR_B_RESET = 5'h19;
  localparam logic [7:0] WRP_PP_RESET = 8'h00;
  localparam int WRP_PTR_LSB = 3;
  localparam int WRP_PAGE_W = 4;
  localparam logic [3:0] WRP_PAGE0 = 4'h0;
  localparam logic [3:0] WRP_PAGE1 = 4'h1;
  localparam logic [3:0] WRP_PAGE2 = 4'h2;
  typedef enum logic [1:0] {
    WRP_MODE_REG = 2'b00,
    WRP_MODE_INDIRECT = 2'b01,
    WRP_MODE_INDEXED = 2'b10,
    WRP_MODE_OTHER = 2'b11
  } wrp_mode_t;
endpackage : wrp_pkg

//--- wrp_ptr_reg.sv
// one working slice pointer: five stored bits, low three fixed at zero
`timescale 1ns/1ps
`default_nettype none
module wrp_ptr_reg #(
  parameter logic [4:0] RESET_VAL = 5'h00
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // value
  output logic [7:0] value
);
  logic [4:0] ptr;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ptr <= RESET_VAL;
    end else if (wr_en) begin
      ptr <= wr_data[7:3];
    end
  end
  assign value = {ptr, 3'h0};
endmodule : wrp_ptr_reg
`default_nettype wire

//--- testbench.sv
// self-checking bench for the working register pointer block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wrp_pkg::*;
  logic clk_sys, rst_n, reg_wr, reg_rd, rd_q, reg_hit, dst_v, src_v, dst_g, src_g;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, work_addr, v, sa, sb;
  logic sm_dv, sm_sv, sm_dg, sm_sg;
  logic [3:0] work_sel, dst_page, src_page;
  wrp_mode_t reg_mode;
  logic [8:0] exp_q[$];
  logic [31:0] seed = 32'h8c7b;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  wrp_core i_wrp_core (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_mode(reg_mode), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .work_sel(work_sel), .work_addr(work_addr),
    .slice_base_a(sa), .slice_base_b(sb), .dst_page(dst_page), .src_page(src_page),
    .dst_page_valid(dst_v), .src_page_valid(src_v), .dst_page_general(dst_g),
    .src_page_general(src_g));
  // small part with page 2 left general, to reach the other page map
  wrp_core #(.LARGE_VARIANT(1'b0), .PAGE2_DISPLAY(1'b0)) i_wrp_core_small (.clk_sys(clk_sys),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_mode(reg_mode), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(), .reg_hit(), .work_sel(work_sel), .work_addr(),
    .slice_base_a(), .slice_base_b(), .dst_page(), .src_page(),
    .dst_page_valid(sm_dv), .src_page_valid(sm_sv), .dst_page_general(sm_dg),
    .src_page_general(sm_sg));
  function logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr
  task test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task chk(input string what, input logic [8:0] e, got);
    n_checks++;
    if (got !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, e, got);
    end
  endtask : chk
  // strobe held exactly one cycle, released at the edge that takes it
  task acc(input logic w, input logic [7:0] a, d, input wrp_mode_t m);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    reg_mode <= m;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : acc
  task rd(input logic [7:0] a, input wrp_mode_t m, input logic [8:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00, m);
  endtask : rd
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    rd_q <= reg_rd;
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      test_done;
    end
  end
  // answer is registered, so compare mid-cycle after the taking edge
  always @(negedge clk_sys) begin
    if (rd_q && exp_q.size() > 0) begin
      chk("read answer", exp_q.pop_front(), {reg_hit, reg_rdata});
    end
  end
  initial begin
    rst_n = 1'b0;
    rd_q = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_mode = WRP_MODE_REG;
    work_sel = 4'h0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(WRP_PTR_A_ADDR, WRP_MODE_REG, {1'b1, WRP_PTR_A_RESET, 3'b000});
    rd(WRP_PTR_B_ADDR, WRP_MODE_REG, {1'b1, WRP_PTR_B_RESET, 3'b000});
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      acc(1'b1, WRP_PTR_A_ADDR, seed[7:0], WRP_MODE_REG);
      acc(1'b1, WRP_PTR_B_ADDR, seed[15:8], WRP_MODE_REG);
      rd(WRP_PTR_A_ADDR, WRP_MODE_REG, {1'b1, seed[7:3], 3'b000});
      rd(WRP_PTR_B_ADDR, WRP_MODE_REG, {1'b1, seed[15:11], 3'b000});
      work_sel <= seed[19:16];
      @(negedge clk_sys);
      v = seed[19] ? {seed[15:11], seed[18:16]} : {seed[7:3], seed[18:16]};
      chk("work address", {1'b0, v}, {1'b0, work_addr});
      chk("slice a", {1'b0, seed[7:3], 3'b000}, {1'b0, sa});
      chk("slice b", {1'b0, seed[15:11], 3'b000}, {1'b0, sb});
    end
    for (int m = 1; m < 4; m++) begin
      acc(1'b1, WRP_PTR_A_ADDR, 8'h08, wrp_mode_t'(m));
      rd(WRP_PTR_A_ADDR, wrp_mode_t'(m), 9'h000);
    end
    rd(WRP_PTR_A_ADDR, WRP_MODE_REG, {1'b1, seed[7:3], 3'b000});
    rd(8'hd8, WRP_MODE_REG, 9'h000);
    for (int p = 0; p < 4; p++) begin
      acc(1'b1, WRP_PP_ADDR, {p[3:0], 4'(3 - p)}, WRP_MODE_REG);
      @(negedge clk_sys);
      chk("page valid", {8'h00, p < 3}, {8'h00, dst_v});
      chk("page general", {7'h00, p < 2, 3 - p < 2}, {7'h00, dst_g, src_g});
      chk("page fields", {1'b0, p[3:0], 4'(3 - p)}, {1'b0, dst_page, src_page});
      chk("src valid", {8'h00, p > 0}, {8'h00, src_v});
      chk("small valid", {7'h00, p == 0 || p == 2, p == 3 || p == 1}, {7'h00, sm_dv, sm_sv});
      chk("small general", {7'h00, p == 0 || p == 2, p == 3 || p == 1}, {7'h00, sm_dg, sm_sg});
    end
    repeat (2) @(posedge clk_sys);
    test_done;
  end
endmodule : testbench
`default_nettype wire
